// ==== core/thermal_pkg.sv ====
// Purpose: shared constants and carrier types of the thermal compensation and fault core
// Assumes: 8-bit register port, one clock, values in the breakpoint table are two's complement
// Notes: register offsets are byte addresses on the plain register port
// How it works
// - three fault flags drive fault pin low
// - eeprom fault latched until reset, never masked
// - all-zero eeprom read gives no checksum error
// - over-temperature flag follows threshold compare, unlatched
// - threshold code all ones disables alarm
// - open-input flag unlatched, needs an enable
// - interpolated part applied only while enable bit set
// - interpolate between the two bracketing breakpoints
// - two to sixteen breakpoints, five values each
// - table read from eeprom location 0x10
// - eeprom location n at wire address 128+n
// - entry with temperature 255 ends table
// - final value is interpolated plus tracking value
// - tracking values written by software or auto
// - sensor power-down lets raw register force temperature
// - clock probe bit shows clock on fault pin
// - divider bit selects full or halved clock
// - threshold is code times 16 plus 144
// - filtered corrected reading feeds alarm and interpolation
package thermal_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_OPEN_EN = 8'h04;
  localparam logic [7:0] ADDR_CORR = 8'h05;
  localparam logic [7:0] ADDR_TEST = 8'h0e;
  localparam logic [7:0] ADDR_THERMAL = 8'h12;
  localparam logic [7:0] ADDR_TRACK0 = 8'h20;
  localparam logic [7:0] ADDR_RAW = 8'h40;
  // field positions
  localparam int CTRL_COMP_EN_BIT = 0;
  localparam int ST_OPEN_BIT = 7;
  localparam int ST_TEMP_BIT = 6;
  localparam int ST_EE_BIT = 5;
  localparam int ST_CODE_LSB = 2;
  localparam int TEST_PD_BIT = 0;
  localparam int TEST_PROBE_BIT = 1;
  localparam int TEST_DIV_BIT = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h04;
  localparam logic [7:0] CORR_RST = 8'h00;
  localparam logic [2:0] ALARM_CODE_RST = 3'h0;
  // alarm threshold
  localparam logic [2:0] ALARM_OFF = 3'h7;
  localparam logic [8:0] ALARM_BASE = 9'h090;
  localparam int ALARM_STEP_LOG2 = 4;
  // table layout
  localparam logic [7:0] LUT_BASE = 8'h10;
  localparam logic [7:0] WIRE_EE_BASE = 8'h80;
  localparam logic [7:0] LAST_TEMP = 8'hff;
  localparam int N_BP = 16;
  localparam int N_VAL = 5;
  localparam logic [2:0] LAST_FIELD = 3'h5;
  // filter
  localparam logic [7:0] HYST = 8'h02;
  localparam logic [9:0] FINE_BIAS = 10'h008;

  typedef logic signed [7:0] val_t;
  typedef val_t [N_VAL-1:0] vals_t; // gain a, gain b, offset a, offset b, offset z
  typedef logic signed [8:0] fval_t;
  typedef fval_t [N_VAL-1:0] fvals_t;

  typedef struct packed {
    logic [7:0] temp;
    vals_t val;
  } bp_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    LD_READ = 2'h0,
    LD_CKSUM = 2'h1,
    LD_DONE = 2'h3
  } load_st_t;
endpackage

// ==== core/interp_lane.sv ====
// Purpose: one lane of piecewise-linear interpolation between two breakpoints
// Assumes: lo_temp_i <= temp_i <= hi_temp_i
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module interp_lane
  import thermal_pkg::*;
(
  input wire logic [7:0] temp_i,
  input wire logic [7:0] lo_temp_i,
  input wire logic [7:0] hi_temp_i,
  input wire val_t lo_val_i,
  input wire val_t hi_val_i,
  output val_t interp_o
);
  logic signed [8:0] rise;
  logic signed [8:0] run;
  logic signed [8:0] pos;
  logic signed [17:0] prod;
  logic signed [17:0] step;

  // slope times distance; a zero distance or span leaves the lower value untouched
  always_comb begin
    rise = 9'(lo_val_i);
    rise = 9'(hi_val_i) - rise;
    run = $signed({1'b0, hi_temp_i}) - $signed({1'b0, lo_temp_i});
    pos = $signed({1'b0, temp_i}) - $signed({1'b0, lo_temp_i});
    prod = rise * pos;
    if (run <= 9'sd0 || pos == 9'sd0) begin
      step = '0;
    end else begin
      step = prod / 18'(run);
    end
    interp_o = lo_val_i + 8'(step);
  end
endmodule

// ==== core/thermal_comp_fault.sv ====
// Purpose: fault status, table-driven temperature compensation and test controls
// Assumes: eeprom transport and sensor adc sit on core_clk_i; open detectors are async pins
// Notes: the table is loaded once after reset; outputs of the lanes are registered here
`timescale 1ns/1ps
module thermal_comp_fault
  import thermal_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] adc_code_i,
  output logic sensor_powerdown_o,
  input wire logic [2:0] open_detect_i,
  output logic ee_rd_req_o,
  output logic [7:0] ee_addr_o,
  input wire logic [7:0] ee_data_i,
  input wire logic ee_ack_i,
  input wire logic ee_err_i,
  input wire logic [7:0] wire_addr_i,
  output logic wire_ee_sel_o,
  output logic [7:0] wire_ee_addr_o,
  input wire logic auto_update_i,
  input wire vals_t auto_vals_i,
  output fvals_t final_vals_o,
  output logic lut_ready_o,
  output logic sys_tick_o,
  output logic fault_out_n_o
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] alarm_code;
    logic ee_fault;
    logic over_temp;
    logic open_flag;
    logic [1:0] open_en;
    logic [7:0] test;
    logic [7:0] corr;
    logic [7:0] forced_raw;
    logic [7:0] held_raw;
    logic [7:0] thermal;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] open_seen;
    vals_t track;
    vals_t interp;
    fvals_t final_v;
    bp_t [N_BP-1:0] lut;
    load_st_t ld;
    logic [6:0] byte_cnt;
    logic [3:0] entry;
    logic [2:0] field;
    logic [7:0] sum;
    logic any_one;
    logic [3:0] last_entry;
    logic lut_ok;
    logic div_phase;
    logic sys_tick;
    logic probe_q;
    logic fault_n;
    logic [7:0] rdata;
    logic wire_sel;
    logic [7:0] wire_addr;
  } state_t;

  state_t st_reg;
  state_t st_next;
  vals_t lane_out;
  logic [3:0] lo_idx;
  logic [3:0] hi_idx;
  logic [7:0] raw;
  logic [7:0] diff;
  logic [9:0] corrected;
  logic [8:0] threshold;
  logic ee_bad;

  // bracket search: last valid breakpoint not above the reading
  always_comb begin
    lo_idx = '0;
    for (int i = 0; i < N_BP; i++) begin
      if (4'(i) <= st_reg.last_entry && st_reg.lut[i].temp <= st_reg.thermal) begin
        lo_idx = 4'(i);
      end
    end
    hi_idx = (lo_idx == st_reg.last_entry) ? lo_idx : lo_idx + 4'h1;
  end

  // one interpolation lane per table value
  for (genvar g = 0; g < N_VAL; g++) begin : g_lane
    interp_lane u_lane (
      .temp_i(st_reg.thermal),
      .lo_temp_i(st_reg.lut[lo_idx].temp),
      .hi_temp_i(st_reg.lut[hi_idx].temp),
      .lo_val_i(st_reg.lut[lo_idx].val[g]),
      .hi_val_i(st_reg.lut[hi_idx].val[g]),
      .interp_o(lane_out[g])
    );
  end

  // next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    ee_bad = 1'b0;

    // raw reading: forced value stands in while the sensor is powered down
    raw = st_reg.test[TEST_PD_BIT] ? st_reg.forced_raw : adc_code_i;
    diff = (raw > st_reg.held_raw) ? raw - st_reg.held_raw : st_reg.held_raw - raw;
    if (diff > HYST) begin
      st_next.held_raw = raw;
    end
    // fine correction adds corr[7:4] - 8, clamped to the code range
    corrected = {2'b00, st_reg.held_raw} + {6'h00, st_reg.corr[7:4]};
    if (corrected < FINE_BIAS) begin
      st_next.thermal = 8'h00;
    end else if (corrected - FINE_BIAS > 10'h0ff) begin
      st_next.thermal = 8'hff;
    end else begin
      st_next.thermal = 8'(corrected - FINE_BIAS);
    end

    // over-temperature compare, never latched
    threshold = {2'b00, st_reg.alarm_code, 4'h0} + ALARM_BASE;
    st_next.over_temp = (st_reg.alarm_code != ALARM_OFF)
      && ({1'b0, st_reg.thermal} > threshold);

    // open-input detectors: three stages, a change counts once stages two and three agree
    st_next.sync1 = open_detect_i;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int i = 0; i < 3; i++) begin
      if (st_reg.sync2[i] == st_reg.sync3[i]) begin
        st_next.open_seen[i] = st_reg.sync3[i];
      end
    end
    st_next.open_flag = (st_reg.open_en[0] && (st_reg.open_seen[0] || st_reg.open_seen[1]))
      || (st_reg.open_en[1] && st_reg.open_seen[2]);

    // table loader; the ee fault flag is only ever set here, so no clear can race it
    unique case (st_reg.ld)
      LD_READ: begin
        if (ee_ack_i) begin
          st_next.byte_cnt = st_reg.byte_cnt + 7'h01;
          st_next.sum = st_reg.sum + ee_data_i;
          st_next.any_one = st_reg.any_one | (|ee_data_i);
          if (st_reg.field == 3'h0) begin
            st_next.lut[st_reg.entry].temp = ee_data_i;
          end else begin
            st_next.lut[st_reg.entry].val[3'(st_reg.field - 3'h1)] = ee_data_i;
          end
          if (st_reg.field == LAST_FIELD) begin
            st_next.field = 3'h0;
            if (st_reg.lut[st_reg.entry].temp == LAST_TEMP) begin
              st_next.last_entry = st_reg.entry;
              st_next.ld = LD_CKSUM;
              // a first entry already at 255 leaves fewer than two breakpoints
              ee_bad = (st_reg.entry == 4'h0) && st_next.any_one;
            end else if (st_reg.entry == 4'(N_BP - 1)) begin
              st_next.ld = LD_DONE;
              ee_bad = st_next.any_one;
            end else begin
              st_next.entry = st_reg.entry + 4'h1;
            end
          end else begin
            st_next.field = st_reg.field + 3'h1;
          end
        end
      end
      LD_CKSUM: begin
        if (ee_ack_i) begin
          st_next.ld = LD_DONE;
          // a line stuck at zero reads all zero bytes and must not flag a checksum error
          if (ee_data_i != st_reg.sum && (st_reg.any_one || ee_data_i != 8'h00)) begin
            ee_bad = 1'b1;
          end else begin
            st_next.lut_ok = 1'b1;
          end
        end
      end
      LD_DONE: begin
      end
      default: begin
        st_next.ld = LD_DONE;
      end
    endcase
    if (ee_err_i && st_reg.ld != LD_DONE) begin
      st_next.ld = LD_DONE;
      st_next.lut_ok = 1'b0;
    end
    if (ee_bad || ee_err_i) begin
      st_next.ee_fault = 1'b1;
    end

    // tracking values: software write wins over an auto update in the same cycle
    if (auto_update_i) begin
      st_next.track = auto_vals_i;
    end

    // compensation: interpolated part only while enabled and the table is good
    for (int i = 0; i < N_VAL; i++) begin
      if (st_reg.ctrl[CTRL_COMP_EN_BIT] && st_reg.lut_ok) begin
        st_next.interp[i] = lane_out[i];
      end else begin
        st_next.interp[i] = 8'sh00;
      end
      st_next.final_v[i] = 9'(st_reg.interp[i]) + 9'(st_reg.track[i]);
    end

    // system tick: every cycle, or every other cycle when halved
    st_next.div_phase = ~st_reg.div_phase;
    st_next.sys_tick = st_reg.test[TEST_DIV_BIT] | st_reg.div_phase;
    if (st_reg.sys_tick) begin
      st_next.probe_q = ~st_reg.probe_q;
    end

    // fault pin: probe clock takes the pin over, otherwise any flag pulls it low
    if (st_reg.test[TEST_PROBE_BIT]) begin
      st_next.fault_n = st_reg.probe_q;
    end else begin
      st_next.fault_n = ~(st_reg.ee_fault | st_reg.over_temp | st_reg.open_flag);
    end

    // single-wire window onto the eeprom
    st_next.wire_sel = wire_addr_i >= WIRE_EE_BASE;
    st_next.wire_addr = wire_addr_i - WIRE_EE_BASE;

    // register writes
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        ADDR_CTRL: st_next.ctrl = bus_i.wdata;
        ADDR_STATUS: st_next.alarm_code = bus_i.wdata[ST_CODE_LSB +: 3];
        ADDR_OPEN_EN: st_next.open_en = bus_i.wdata[1:0];
        ADDR_CORR: st_next.corr = bus_i.wdata;
        ADDR_TEST: st_next.test = bus_i.wdata;
        ADDR_RAW: st_next.forced_raw = bus_i.wdata;
        default: begin
          for (int i = 0; i < N_VAL; i++) begin
            if (bus_i.addr == ADDR_TRACK0 + 8'(i)) begin
              st_next.track[i] = bus_i.wdata;
            end
          end
        end
      endcase
    end

    // register reads: data valid the cycle after the strobe only
    st_next.rdata = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ADDR_CTRL: st_next.rdata = st_reg.ctrl;
        ADDR_STATUS: st_next.rdata = {st_reg.open_flag, st_reg.over_temp, st_reg.ee_fault,
                                      st_reg.alarm_code, 2'b00};
        ADDR_OPEN_EN: st_next.rdata = {6'h00, st_reg.open_en};
        ADDR_CORR: st_next.rdata = st_reg.corr;
        ADDR_TEST: st_next.rdata = st_reg.test;
        ADDR_THERMAL: st_next.rdata = st_reg.thermal;
        ADDR_RAW: st_next.rdata = raw;
        default: begin
          for (int i = 0; i < N_VAL; i++) begin
            if (bus_i.addr == ADDR_TRACK0 + 8'(i)) begin
              st_next.rdata = st_reg.track[i];
            end
          end
        end
      endcase
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RST;
      st_reg.test <= TEST_RST;
      st_reg.corr <= CORR_RST;
      st_reg.alarm_code <= ALARM_CODE_RST;
      st_reg.ld <= LD_READ;
      st_reg.fault_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign rdata_o = st_reg.rdata;
  assign sensor_powerdown_o = st_reg.test[TEST_PD_BIT];
  assign ee_rd_req_o = (st_reg.ld == LD_READ) || (st_reg.ld == LD_CKSUM);
  assign ee_addr_o = LUT_BASE + {1'b0, st_reg.byte_cnt};
  assign wire_ee_sel_o = st_reg.wire_sel;
  assign wire_ee_addr_o = st_reg.wire_addr;
  assign final_vals_o = st_reg.final_v;
  assign lut_ready_o = st_reg.lut_ok;
  assign sys_tick_o = st_reg.sys_tick;
  assign fault_out_n_o = st_reg.fault_n;
endmodule

// ==== testbench/thermal_props_properties.sv ====
// Purpose: port checks of the thermal compensation and fault core
// Assumes: bound into every instance of the core
// Notes: small age counters stand in for long waits
`timescale 1ns/1ps
module thermal_props
  import thermal_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic sensor_powerdown_o,
  input wire logic ee_rd_req_o,
  input wire logic [7:0] ee_addr_o,
  input wire logic ee_ack_i,
  input wire logic ee_err_i,
  input wire logic [7:0] wire_addr_i,
  input wire logic wire_ee_sel_o,
  input wire logic [7:0] wire_ee_addr_o,
  input wire logic sys_tick_o,
  input wire logic fault_out_n_o
);
  logic [1:0] settle_reg;
  logic [1:0] ee_age_reg;
  logic [7:0] test_reg;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence test_write;
    bus_i.wr && bus_i.addr == ADDR_TEST;
  endsequence
  sequence status_read;
    bus_i.rd && bus_i.addr == ADDR_STATUS;
  endsequence
  sequence byte_taken;
    ee_rd_req_o && ee_ack_i;
  endsequence
  // shadow test register; ages let outputs settle before they are judged
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_reg <= 2'h0;
      ee_age_reg <= 2'h0;
      test_reg <= TEST_RST;
    end else begin
      settle_reg <= (bus_i.wr && bus_i.addr == ADDR_TEST) ? 2'h0 : settle_reg + {1'b0, settle_reg != 2'h3};
      ee_age_reg <= ee_err_i ? 2'h1 : ee_age_reg + {1'b0, ee_age_reg != 2'h0 && ee_age_reg != 2'h3};
      if (bus_i.wr && bus_i.addr == ADDR_TEST) test_reg <= bus_i.wdata;
    end
  end
  chk_powerdown_write: assert property (test_write |=>
    sensor_powerdown_o == $past(bus_i.wdata[TEST_PD_BIT])) else $error("powerdown bit wrong");
  chk_ee_flag_held: assert property (status_read ##0 ee_age_reg == 2'h3 |=>
    rdata_o[ST_EE_BIT]) else $error("eeprom fault flag lost");
  chk_fault_pin_ee: assert property (ee_age_reg == 2'h3 && settle_reg == 2'h3 &&
    !test_reg[TEST_PROBE_BIT] |-> !fault_out_n_o) else $error("fault pin not low");
  chk_table_start: assert property (!$past(reset_n_i) |->
    ee_rd_req_o && ee_addr_o == LUT_BASE) else $error("table not read from its base");
  chk_table_step: assert property (byte_taken |=>
    !ee_rd_req_o || ee_addr_o == $past(ee_addr_o) + 8'h01) else $error("table address skipped");
  chk_wire_map: assert property (1'b1 |=> wire_ee_sel_o == $past(wire_addr_i[7]) &&
    (!wire_ee_sel_o || wire_ee_addr_o == $past(wire_addr_i) - WIRE_EE_BASE)) else $error("wire map");
  chk_tick_full: assert property (settle_reg == 2'h3 && test_reg[TEST_DIV_BIT] |->
    sys_tick_o) else $error("full rate tick wrong");
  chk_tick_half: assert property (settle_reg == 2'h3 && !test_reg[TEST_DIV_BIT] |->
    sys_tick_o != $past(sys_tick_o)) else $error("half rate tick wrong");
  chk_probe_toggle: assert property (settle_reg == 2'h3 && test_reg[2:1] == 2'h3 |->
    fault_out_n_o != $past(fault_out_n_o)) else $error("probe clock missing");
endmodule
bind thermal_comp_fault thermal_props u_props (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .sensor_powerdown_o(sensor_powerdown_o),
  .ee_rd_req_o(ee_rd_req_o), .ee_addr_o(ee_addr_o), .ee_ack_i(ee_ack_i), .ee_err_i(ee_err_i),
  .wire_addr_i(wire_addr_i), .wire_ee_sel_o(wire_ee_sel_o), .wire_ee_addr_o(wire_ee_addr_o),
  .sys_tick_o(sys_tick_o), .fault_out_n_o(fault_out_n_o));

// ==== testbench/ee_table_model.sv ====
// Purpose: eeprom transport stand-in serving the breakpoint table
// Assumes: one byte per request, answered promptly or slowly
// Notes: data changes every cycle outside an answer
`timescale 1ns/1ps
module ee_table_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic slow_i,
  input wire logic rd_req_i,
  input wire logic [7:0] addr_i,
  output logic [7:0] data_o,
  output logic ack_o
);
  logic [7:0] mem [256];
  logic [2:0] wait_reg;
  // a gap after each answer lets the core move its address first
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      wait_reg <= 3'h0;
      data_o <= 8'h00;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      wait_reg <= 3'h0;
      data_o <= ~data_o;
    end else if (rd_req_i && wait_reg >= (slow_i ? 3'h4 : 3'h0)) begin
      ack_o <= 1'b1;
      data_o <= mem[addr_i];
    end else begin
      data_o <= ~data_o;
      if (wait_reg != 3'h7) wait_reg <= wait_reg + 3'h1;
    end
  end
endmodule

// ==== testbench/tb_thermal_comp_fault.sv ====
// Purpose: directed bench for the thermal compensation and fault core
// Assumes: inputs change on the rising edge or just after it
// Notes: the core loads its table once per reset, so each image needs a reset
`timescale 1ns/1ps
module tb_thermal_comp_fault;
  import thermal_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  bus_req_t bus = '0;
  logic [7:0] rdata, ee_addr, ee_data, wire_ee_addr, adc = 8'h30, wire_addr = 8'h00;
  logic [2:0] open_det = 3'h0;
  logic pd, req, ack, wire_sel, ready, tick, fault_n, last, ee_err = 1'b0;
  logic auto_up = 1'b0, slow = 1'b0;
  vals_t auto_vals = '0;
  fvals_t finals;
  int err_count = 0, checks_done = 0, cycles = 0;
  int trk [5] = '{0, 0, 0, 0, 0};
  int bpv [5] = '{64, -64, 32, 16, 8};
  logic [7:0] tab [19] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h40, 8'hc0,
    8'h20, 8'h10, 8'h08, 8'hff, 8'h40, 8'hc0, 8'h20, 8'h10, 8'h08, 8'hef};
  always #12.5 clk = ~clk;
  thermal_comp_fault u_dut (.core_clk_i(clk), .reset_n_i(reset_n), .bus_i(bus), .rdata_o(rdata),
    .adc_code_i(adc), .sensor_powerdown_o(pd), .open_detect_i(open_det), .ee_rd_req_o(req),
    .ee_addr_o(ee_addr), .ee_data_i(ee_data), .ee_ack_i(ack), .ee_err_i(ee_err),
    .wire_addr_i(wire_addr), .wire_ee_sel_o(wire_sel), .wire_ee_addr_o(wire_ee_addr),
    .auto_update_i(auto_up), .auto_vals_i(auto_vals), .final_vals_o(finals),
    .lut_ready_o(ready), .sys_tick_o(tick), .fault_out_n_o(fault_n));
  ee_table_model u_ee (.clk_i(clk), .reset_n_i(reset_n), .slow_i(slow), .rd_req_i(req),
    .addr_i(ee_addr), .data_o(ee_data), .ack_o(ack));
  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk("rdata", {1'b0, e}, {1'b0, rdata});
    // read data stands for one cycle only, then the port returns to zero
    @(posedge clk);
    #1;
    chk("rdata_idle", 9'h000, {1'b0, rdata});
  endtask
  // halves counts breakpoint values in halves: 0 off, 1 midway, 2 on the breakpoint
  task automatic fin(input int halves);
    for (int i = 0; i < 5; i++) chk("final", 9'(bpv[i] * halves / 2 + trk[i]), finals[i]);
  endtask
  // kind 0 all zero image, 1 bad checksum, 2 good table with junk after its end
  task automatic restart(input int kind);
    @(posedge clk);
    reset_n <= 1'b0;
    for (int i = 0; i < 256; i++) u_ee.mem[i] = (kind > 0 && i == 35) ? 8'h55 : 8'h00;
    for (int i = 0; i < 19; i++) if (kind > 0) u_ee.mem[16 + i] = tab[i];
    if (kind == 1) u_ee.mem[34] = 8'h00;
    idle(2);
    chk("ee_addr", {1'b0, LUT_BASE}, {1'b0, ee_addr});
    @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 600 && req; i++) @(posedge clk);
    idle(2);
  endtask
  initial begin
    restart(0);
    chk("ready", 9'h000, {8'h00, ready});
    rd(ADDR_STATUS, 8'h00);
    restart(1);
    chk("ready", 9'h000, {8'h00, ready});
    rd(ADDR_STATUS, 8'h20);
    slow <= 1'b1;
    restart(2);
    chk("ready", 9'h001, {8'h00, ready});
    chk("fault_pin", 9'h001, {8'h00, fault_n});
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_TEST, TEST_RST);
    rd(ADDR_CORR, CORR_RST);
    rd(8'h7f, 8'h00);
    rd(ADDR_RAW, 8'h30);
    rd(ADDR_THERMAL, 8'h28);
    wr(ADDR_CORR, 8'h80);
    wr(ADDR_TEST, 8'h05);
    wr(ADDR_RAW, 8'h40);
    wr(ADDR_CTRL, 8'h01);
    idle(6);
    chk("powerdown", 9'h001, {8'h00, pd});
    rd(ADDR_THERMAL, 8'h40);
    fin(1);
    wr(ADDR_RAW, 8'h80);
    idle(6);
    fin(2);
    @(posedge clk);
    auto_vals <= {8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
    auto_up <= 1'b1;
    @(posedge clk);
    auto_up <= 1'b0;
    wr(ADDR_TRACK0, 8'hf6);
    trk = '{-10, 2, 3, 4, 5};
    idle(4);
    fin(2);
    wr(ADDR_CTRL, 8'h00);
    idle(4);
    fin(0);
    wr(ADDR_RAW, 8'h91);
    idle(6);
    rd(ADDR_STATUS, 8'h40);
    chk("fault_pin", 9'h000, {8'h00, fault_n});
    wr(ADDR_RAW, 8'h8d);
    idle(3);
    wr(ADDR_RAW, 8'h90);
    idle(6);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_STATUS, 8'h1c);
    wr(ADDR_RAW, 8'hff);
    idle(6);
    rd(ADDR_STATUS, 8'h1c);
    wr(ADDR_STATUS, 8'h18);
    idle(6);
    rd(ADDR_STATUS, 8'h58);
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_RAW, 8'h20);
    @(posedge clk);
    open_det <= 3'h1;
    idle(8);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_OPEN_EN, 8'h01);
    idle(8);
    rd(ADDR_STATUS, 8'h80);
    chk("fault_pin", 9'h000, {8'h00, fault_n});
    @(posedge clk);
    open_det <= 3'h0;
    idle(8);
    rd(ADDR_STATUS, 8'h00);
    @(posedge clk);
    wire_addr <= 8'h85;
    idle(2);
    chk("wire_ee_addr", 9'h105, {wire_sel, wire_ee_addr});
    wr(ADDR_TEST, 8'h07);
    idle(4);
    last = fault_n;
    idle(1);
    chk("probe", {8'h00, ~last}, {8'h00, fault_n});
    wr(ADDR_TEST, 8'h01);
    idle(4);
    last = tick;
    idle(1);
    chk("tick", {8'h00, ~last}, {8'h00, tick});
    wr(ADDR_TEST, 8'h05);
    idle(4);
    chk("tick", 9'h001, {8'h00, tick});
    @(posedge clk);
    ee_err <= 1'b1;
    @(posedge clk);
    ee_err <= 1'b0;
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h20);
    chk("fault_pin", 9'h000, {8'h00, fault_n});
    wrap_up();
  end
endmodule
